// ---- hdl/bsp_sync.sv ----
`timescale 1ns/1ps
`default_nettype none

module bsp_sync #(
	parameter int          WIDTH     = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	input  wire logic             clk,
	input  wire logic             srst,
	input  wire logic [WIDTH-1:0] d,
	output var  logic [WIDTH-1:0] q
);

	// ==========================================
	// Two-stage synchroniser per bit
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++)
		begin : g_bit
			logic meta_reg;
			always_ff @(posedge clk)
			begin
				if (srst)
				begin
					meta_reg <= RESET_VAL[i];
					q[i]     <= RESET_VAL[i];
				end
				else
				begin
					meta_reg <= d[i];
					q[i]     <= meta_reg;
				end
			end
		end
	endgenerate

endmodule // bsp_sync

`default_nettype wire

// ---- hdl/bsp_tap.sv ----
// Behaviour
// - Mode select sampled on scan clock rise
// - Data in shifted on rise into selected
// - Data out changes only on falling edge or reset
// - Output floats unless shifting, changes on fall
// - Reset low holds reset state, output floats
// - Undriven mode and data read as one
`timescale 1ns/1ps
`default_nettype none
`include "bsp_defs.svh"

module bsp_tap #(
	parameter int          BSR_LEN = 8,
	parameter logic [31:0] ID_CODE = 32'h0A5C_3001  // Arbitrary value
) (
	input  wire logic               core_clk,
	input  wire logic               srst,
	input  wire logic               scan_clock_in,
	input  wire logic               scan_mode_select_in,
	input  wire logic               scan_serial_in,
	input  wire logic               scan_reset_n,
	output var  logic               scan_serial_out,
	output var  logic               scan_serial_out_oe,
	input  wire logic [BSR_LEN-1:0] bsr_capture_in,
	output var  logic [BSR_LEN-1:0] bsr_update_out,
	output var  logic [`BSP_IR_LEN-1:0] ir_active_out
);
	import bsp_pkg::*;

	// Elaboration check on boundary register length
	if (BSR_LEN < 1)
	begin : g_len_chk
		$error("BSR_LEN must be at least 1");
	end

	// ==========================================
	// Pin synchronisers
	logic [`BSP_SYNC_BITS-1:0] pins_s;
	logic tck_s, tms_s, tdi_s, trst_n_s;
	logic tck_d_reg;
	logic rise, fall, tap_rst;

	bsp_sync #(
		.WIDTH     (`BSP_SYNC_BITS),
		.RESET_VAL (`BSP_SYNC_RESET_VAL)
	) u_sync (
		.clk  (core_clk),
		.srst (srst),
		.d    ({scan_reset_n, scan_serial_in, scan_mode_select_in, scan_clock_in}),
		.q    (pins_s)
	);

	assign tck_s    = pins_s[0];
	assign tms_s    = pins_s[1];
	assign tdi_s    = pins_s[2];
	assign trst_n_s = pins_s[3];
	assign rise     = tck_s & ~tck_d_reg;
	assign fall     = ~tck_s & tck_d_reg;
	assign tap_rst  = srst | ~trst_n_s;

	always_ff @(posedge core_clk)
	begin
		if (srst)
			tck_d_reg <= 1'b0;
		else
			tck_d_reg <= tck_s;
	end

	// ==========================================
	// Controller state machine
	bsp_state_t state_reg, state_next;

	always_comb
	begin
		unique case (state_reg)
			ST_RESET:    state_next = tms_s ? ST_RESET   : ST_IDLE;
			ST_IDLE:     state_next = tms_s ? ST_SEL_DR  : ST_IDLE;
			ST_SEL_DR:   state_next = tms_s ? ST_SEL_IR  : ST_CAP_DR;
			ST_CAP_DR:   state_next = tms_s ? ST_EXIT1_DR : ST_SHIFT_DR;
			ST_SHIFT_DR: state_next = tms_s ? ST_EXIT1_DR : ST_SHIFT_DR;
			ST_EXIT1_DR: state_next = tms_s ? ST_UPD_DR  : ST_PAUSE_DR;
			ST_PAUSE_DR: state_next = tms_s ? ST_EXIT2_DR : ST_PAUSE_DR;
			ST_EXIT2_DR: state_next = tms_s ? ST_UPD_DR  : ST_SHIFT_DR;
			ST_UPD_DR:   state_next = tms_s ? ST_SEL_DR  : ST_IDLE;
			ST_SEL_IR:   state_next = tms_s ? ST_RESET   : ST_CAP_IR;
			ST_CAP_IR:   state_next = tms_s ? ST_EXIT1_IR : ST_SHIFT_IR;
			ST_SHIFT_IR: state_next = tms_s ? ST_EXIT1_IR : ST_SHIFT_IR;
			ST_EXIT1_IR: state_next = tms_s ? ST_UPD_IR  : ST_PAUSE_IR;
			ST_PAUSE_IR: state_next = tms_s ? ST_EXIT2_IR : ST_PAUSE_IR;
			ST_EXIT2_IR: state_next = tms_s ? ST_UPD_IR  : ST_SHIFT_IR;
			ST_UPD_IR:   state_next = tms_s ? ST_SEL_DR  : ST_IDLE;
			default:     state_next = ST_RESET;
		endcase
	end

	always_ff @(posedge core_clk)
	begin
		if (tap_rst)
			state_reg <= ST_RESET;
		else if (rise)
			state_reg <= state_next;
	end

	// ==========================================
	// Instruction register
	logic [`BSP_IR_LEN-1:0] ir_shift_reg;

	always_ff @(posedge core_clk)
	begin
		if (tap_rst)
		begin
			ir_shift_reg  <= `BSP_IR_RESET_VAL;
			ir_active_out <= `BSP_IR_RESET_VAL;
		end
		else if (rise)
		begin
			if (state_reg == ST_RESET)
				ir_active_out <= `BSP_IR_RESET_VAL;
			else if (state_reg == ST_CAP_IR)
				ir_shift_reg <= `BSP_IR_CAPTURE;
			else if (state_reg == ST_SHIFT_IR)
				ir_shift_reg <= {tdi_s, ir_shift_reg[`BSP_IR_LEN-1:1]};
			else if (state_reg == ST_UPD_IR)
				ir_active_out <= ir_shift_reg;
		end
	end

	// ==========================================
	// Data registers
	logic               bypass_reg;
	logic [31:0]        id_shift_reg;
	logic [BSR_LEN-1:0] bsr_shift_reg;
	logic               sel_bsr;

	assign sel_bsr = (ir_active_out == `BSP_OP_EXTEST) || (ir_active_out == `BSP_OP_SAMPLE);

	always_ff @(posedge core_clk)
	begin
		if (tap_rst)
		begin
			bypass_reg    <= 1'b0;
			id_shift_reg  <= 32'h0000_0000;
			bsr_shift_reg <= '0;
		end
		else if (rise && state_reg == ST_CAP_DR)
		begin
			bypass_reg    <= 1'b0;
			id_shift_reg  <= ID_CODE;
			bsr_shift_reg <= bsr_capture_in;
		end
		else if (rise && state_reg == ST_SHIFT_DR)
		begin
			if (ir_active_out == `BSP_OP_IDCODE)
				id_shift_reg <= {tdi_s, id_shift_reg[31:1]};
			else if (sel_bsr)
				bsr_shift_reg <= {tdi_s, bsr_shift_reg[BSR_LEN-1:1]};
			else
				bypass_reg <= tdi_s;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (tap_rst)
			bsr_update_out <= '0;
		else if (rise && state_reg == ST_UPD_DR && sel_bsr)
			bsr_update_out <= bsr_shift_reg;
	end

	// ==========================================
	// Serial output, retimed to falling edge
	logic dr_bit;

	always_comb
	begin
		if (ir_active_out == `BSP_OP_IDCODE)
			dr_bit = id_shift_reg[0];
		else if (sel_bsr)
			dr_bit = bsr_shift_reg[0];
		else
			dr_bit = bypass_reg;
	end

	always_ff @(posedge core_clk)
	begin
		if (tap_rst)
		begin
			scan_serial_out    <= 1'b0;
			scan_serial_out_oe <= 1'b0;
		end
		else if (fall)
		begin
			scan_serial_out_oe <= (state_reg == ST_SHIFT_DR) || (state_reg == ST_SHIFT_IR);
			if (state_reg == ST_SHIFT_IR)
				scan_serial_out <= ir_shift_reg[0];
			else if (state_reg == ST_SHIFT_DR)
				scan_serial_out <= dr_bit;
		end
	end

	// ==========================================
	// Checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);

	sequence s_rise_tms(bit v);
		rise && tms_s == v;
	endsequence

	property p_reset_holds;
		!trst_n_s |=> state_reg == ST_RESET && !scan_serial_out_oe;
	endproperty
	a_reset_holds: assert property (p_reset_holds) else $error("reset not held");

	property p_state_on_rise;
		$changed(state_reg) |-> $past(rise) || $past(!trst_n_s);
	endproperty
	a_state_on_rise: assert property (p_state_on_rise) else $error("state moved off rise");

	property p_leave_reset;
		state_reg == ST_RESET && trst_n_s ##0 s_rise_tms(1'b0) |=> state_reg == ST_IDLE;
	endproperty
	a_leave_reset: assert property (p_leave_reset) else $error("reset exit wrong");

	property p_tdo_on_fall;
		$changed(scan_serial_out) |-> $past(fall) || $past(!trst_n_s);
	endproperty
	a_tdo_on_fall: assert property (p_tdo_on_fall) else $error("output moved off fall");

	property p_oe_on_fall;
		$changed(scan_serial_out_oe) |-> $past(fall) || $past(!trst_n_s);
	endproperty
	a_oe_on_fall: assert property (p_oe_on_fall) else $error("enable moved off fall");

	property p_oe_in_shift;
		fall && trst_n_s && state_reg == ST_SHIFT_DR |=> scan_serial_out_oe;
	endproperty
	a_oe_in_shift: assert property (p_oe_in_shift) else $error("enable missing in shift");

	property p_bypass_shift;
		rise && trst_n_s && state_reg == ST_SHIFT_DR && ir_active_out == `BSP_OP_BYPASS
			|=> bypass_reg == $past(tdi_s);
	endproperty
	a_bypass_shift: assert property (p_bypass_shift) else $error("bypass not shifted");

	property p_capture_ir;
		rise && trst_n_s && state_reg == ST_CAP_IR |=> ir_shift_reg == `BSP_IR_CAPTURE;
	endproperty
	a_capture_ir: assert property (p_capture_ir) else $error("ir capture wrong");

	property p_upd_dr_next;
		state_reg == ST_UPD_DR && trst_n_s ##0 s_rise_tms(1'b1) |=> state_reg == ST_SEL_DR;
	endproperty
	a_upd_dr_next: assert property (p_upd_dr_next) else $error("update exit wrong");

endmodule // bsp_tap

`default_nettype wire

// ---- shared/bsp_defs.svh ----
`ifndef BSP_DEFS_SVH
`define BSP_DEFS_SVH

// ==========================================
// Instruction register
`define BSP_IR_LEN          4
`define BSP_IR_CAPTURE      4'h1
`define BSP_IR_RESET_VAL    4'h2

// ==========================================
// Instruction codes
`define BSP_OP_EXTEST       4'h0
`define BSP_OP_SAMPLE       4'h1
`define BSP_OP_IDCODE       4'h2
`define BSP_OP_BYPASS       4'hF

// ==========================================
// Synchroniser reset values, pulled-up inputs idle high
`define BSP_SYNC_BITS       4
`define BSP_SYNC_RESET_VAL  4'h6

// ==========================================
// Timing
`define BSP_CORE_PERIOD_PS  5000
`define BSP_TCK_MIN_PER_PS  100000
`define BSP_TCK_MIN_CYCLES  ((`BSP_TCK_MIN_PER_PS + `BSP_CORE_PERIOD_PS - 1) / `BSP_CORE_PERIOD_PS)

`endif

// ---- shared/bsp_pkg.sv ----
`default_nettype none

package bsp_pkg;

	// ==========================================
	// Port controller states
	typedef enum logic [15:0]
	{
		ST_RESET      = 16'h0001,
		ST_IDLE       = 16'h0002,
		ST_SEL_DR     = 16'h0004,
		ST_CAP_DR     = 16'h0008,
		ST_SHIFT_DR   = 16'h0010,
		ST_EXIT1_DR   = 16'h0020,
		ST_PAUSE_DR   = 16'h0040,
		ST_EXIT2_DR   = 16'h0080,
		ST_UPD_DR     = 16'h0100,
		ST_SEL_IR     = 16'h0200,
		ST_CAP_IR     = 16'h0400,
		ST_SHIFT_IR   = 16'h0800,
		ST_EXIT1_IR   = 16'h1000,
		ST_PAUSE_IR   = 16'h2000,
		ST_EXIT2_IR   = 16'h4000,
		ST_UPD_IR     = 16'h8000
	} bsp_state_t;

endpackage

`default_nettype wire

// ---- test/bsp_tester.sv ----
`timescale 1ns/1ps
`default_nettype none

// ==========================================
// Scan tester model
module bsp_tester (
	input  wire logic clk,
	output var  logic tck,
	output wire logic tms,
	output wire logic tdi,
	output var  logic trst_n,
	input  wire logic tdo,
	input  wire logic tdo_oe
);
	logic drv = 1'b1;
	logic tms_r = 1'b1;
	logic tdi_r = 1'b1;

	// Released lines go to the pull-up level
	assign tms = drv ? tms_r : 1'b1;
	assign tdi = drv ? tdi_r : 1'b1;

	initial
	begin
		tck = 1'b0;
		trst_n = 1'b0;
	end

	// One scan clock period, 160 ns, even duty, still between calls
	task automatic step(input logic m, input logic d, output logic o, output logic e);
		@(negedge clk);
		tms_r = m;
		tdi_r = d;
		repeat (15) @(negedge clk);
		// Floating output reads as inverse of last value
		o = tdo_oe ? tdo : ~tdo;
		e = tdo_oe;
		tck = 1'b1;
		repeat (16) @(negedge clk);
		tck = 1'b0;
	endtask

	task automatic set_rst(input logic v);
		@(negedge clk);
		trst_n = v;
	endtask
endmodule // bsp_tester

`default_nettype wire

// ---- test/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "bsp_defs.svh"

module tb_top;
	localparam logic [31:0] ID = 32'h1234_5678; // Arbitrary value
	logic             core_clk = 1'b0;
	logic             srst = 1'b1;
	logic [7:0]       cap = 8'h5A;
	wire logic        tck, tms, tdi, trst_n;
	logic             tdo, oe;
	logic [7:0]       upd;
	logic [3:0]       ir;
	int               failures = 0;
	int               comparisons = 0;

	always #2.5 core_clk = ~core_clk;

	bsp_tap #(.BSR_LEN(8), .ID_CODE(ID)) dut (
		.core_clk(core_clk), .srst(srst), .scan_clock_in(tck),
		.scan_mode_select_in(tms), .scan_serial_in(tdi), .scan_reset_n(trst_n),
		.scan_serial_out(tdo), .scan_serial_out_oe(oe), .bsr_capture_in(cap),
		.bsr_update_out(upd), .ir_active_out(ir));

	bsp_tester u_tst (
		.clk(core_clk), .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n),
		.tdo(tdo), .tdo_oe(oe));

	// ==========================================
	// Shared tasks
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e)
		begin
			failures++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic test_done;
		$display("failures %0d comparisons %0d", failures, comparisons);
		if (failures == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// Mode select sequence, first step in bit 0
	task automatic walk(input logic [7:0] seq, input int n);
		logic o, e;
		for (int i = 0; i < n; i++)
			u_tst.step(seq[i], 1'b0, o, e);
	endtask

	// Shift n bits, leave through update to idle
	task automatic shift(input int n, input logic [31:0] din, output logic [31:0] dout);
		logic o, e;
		dout = '0;
		for (int i = 0; i < n; i++)
		begin
			u_tst.step(i == n - 1, din[i], o, e);
			dout[i] = o;
			chk("oe shifting", 1'b1, e);
		end
		u_tst.step(1'b1, 1'b0, o, e);
		chk("oe after exit", 1'b0, e);
		u_tst.step(1'b0, 1'b0, o, e);
	endtask

	task automatic t_ir(input logic [3:0] op);
		logic [31:0] d;
		walk(8'h03, 4);
		shift(4, {28'h000_0000, op}, d);
		chk("ir capture", `BSP_IR_CAPTURE, d);
		chk("ir active", op, ir);
	endtask

	// ==========================================
	// Scenarios
	task automatic t_idcode;
		logic [31:0] d;
		walk(8'h02, 4);
		shift(32, ID, d);
		chk("idcode", ID, d);
	endtask

	task automatic t_bypass;
		logic [31:0] d;
		t_ir(`BSP_OP_BYPASS);
		walk(8'h01, 3);
		shift(4, 32'h0000_000B, d);
		chk("bypass", 32'h0000_0006, d);
		t_ir(4'h7);
		walk(8'h01, 3);
		shift(2, 32'h0000_0003, d);
		chk("unused op bypass", 32'h0000_0002, d);
	endtask

	task automatic t_bsr;
		logic [31:0] d;
		t_ir(`BSP_OP_SAMPLE);
		t_ir(`BSP_OP_IDCODE);
		t_ir(`BSP_OP_EXTEST);
		walk(8'h01, 3);
		shift(8, 32'h0000_00C3, d);
		chk("bsr capture", cap, d);
		chk("bsr update", 8'hC3, upd);
	endtask

	task automatic t_scan_reset;
		walk(8'h01, 4);
		chk("oe in shift", 1'b1, oe);
		u_tst.set_rst(1'b0);
		repeat (6) @(negedge core_clk);
		chk("oe scan reset", 1'b0, oe);
		chk("ir scan reset", `BSP_IR_RESET_VAL, ir);
		u_tst.set_rst(1'b1);
		repeat (4) @(negedge core_clk);
		walk(8'h00, 1);
	endtask

	task automatic t_float;
		t_ir(`BSP_OP_SAMPLE);
		u_tst.drv = 1'b0;
		walk(8'h00, 5);
		chk("ir floating", `BSP_IR_RESET_VAL, ir);
		u_tst.drv = 1'b1;
	endtask

	// ==========================================
	// Main sequence and watchdog
	initial
	begin
		repeat (5) @(negedge core_clk);
		srst = 1'b0;
		chk("oe reset", 1'b0, oe);
		chk("ir reset", `BSP_IR_RESET_VAL, ir);
		chk("bsr reset", 8'h00, upd);
		u_tst.set_rst(1'b1);
		repeat (4) @(negedge core_clk);
		t_idcode();
		t_bypass();
		t_bsr();
		t_scan_reset();
		t_float();
		test_done();
	end

	initial
	begin
		repeat (50000) @(posedge core_clk);
		failures++;
		test_done();
	end
endmodule // tb_top

`default_nettype wire
